// file: src/fpme_entry.sv
/*
 * Flash program mode entry: recognises the tool's entry sequence while
 * the reset pin is low, picks the reset vector and the clock source,
 * stores the downloaded driver in RAM and grants flash operations by mode.
 * Assumes the tool owns the reset pin during a session and that the
 * serial clock is the link clock, stopped or slow outside a session.
 */
// Summary of operation
// - flash takes single bytes or rows of up to 32 bytes
// - erase touches only the addressed sector
// - tool programming may write and erase sector 0, 1 and option row
// - in-application mode may write and erase sector 1 while running
// - in-application mode protects sector 0 against write and erase
// - on valid entry fetch system memory vector, run byte receive routine
// - tool sends driver serially; device stores it in RAM to run
// - 35-pulse entry uses the external clock input supplied by the tool
// - 38-pulse entry forces main RC if selected, else wake-up RC
// - any reset returns serial clock pin to input with pull-up
`timescale 1ns/10ps
`include "fpme_cfg.svh"

module fpme_entry
    import fpme_pkg::*;
(
    input  wire logic                   i_core_clk,
    input  wire logic                   i_reset,
    input  wire logic                   i_prog_serial_clock,
    input  wire logic                   i_prog_serial_data,
    input  wire logic                   i_reset_pin_n,
    input  wire logic                   i_opt_bytes_en,
    input  wire logic                   i_opt_main_rc_sel,
    input  wire logic                   i_iap_active,
    input  wire logic                   i_app_ser_clk_drive,
    input  wire fpme_flash_req_t        i_flash_req,
    input  wire logic [`FPME_RAM_AW-1:0] i_ram_addr,
    output logic                        o_in_circuit_comm,
    output logic                        o_vec_sys,
    output logic                        o_cpu_start,
    output fpme_clk_src_t               o_clk_src,
    output logic [7:0]                  o_rx_cnt,
    output logic [7:0]                  o_ram_rdata,
    output logic                        o_flash_grant,
    output logic                        o_flash_deny,
    output logic [2:0]                  o_erase_mask,
    output logic                        o_ser_clk_oe_n,
    output logic                        o_ser_clk_pu
);

    fpme_core_t                 r;
    fpme_core_t                 n;
    logic [7:0]                 ram [0:`FPME_RAM_DEPTH-1];
    logic [`FPME_CNT_W-1:0]     lnk_gray;
    logic [7:0]                 lnk_byte;
    logic                       lnk_tog;
    logic [`FPME_CNT_W-1:0]     pulses;
    logic [`FPME_CNT_W-1:0]     need;
    logic                       byte_evt;
    logic                       ram_we;

    // operation is allowed if the mode owns the sector and the size fits
    function automatic logic flash_ok(input fpme_state_t st,
                                      input logic in_application_programming,
                                      input fpme_flash_req_t q);
        logic sec_ok;
        logic len_ok;
        sec_ok = 1'b0;
        if (st == FPME_ST_COMM) begin
            sec_ok = (q.sector != 2'b11);
        end else if (st == FPME_ST_RUN && in_application_programming) begin
            sec_ok = (q.sector == FPME_SEC1);
        end
        len_ok = 1'b1;
        if (q.op == FPME_OP_ROW) begin
            len_ok = (q.len != 6'h00) && (q.len <= `FPME_ROW_MAX);
        end else if (q.op != FPME_OP_BYTE && q.op != FPME_OP_ERASE) begin
            len_ok = 1'b0;
        end
        return sec_ok && len_ok;
    endfunction : flash_ok

    fpme_link u_link (
        .i_link_clk     (i_prog_serial_clock),
        .i_reset        (i_reset),
        .i_reset_pin_n  (i_reset_pin_n),
        .i_ser_data     (i_prog_serial_data),
        .o_gray         (lnk_gray),
        .o_byte         (lnk_byte),
        .o_byte_tog     (lnk_tog)
    );

    ////////////////////////////////////////////////////////////////////////
    // pulse count since the reset pin fell, and required count per mode
    assign pulses   = fpme_gray2bin(r.g_s2) - r.base;
    assign need     = i_opt_bytes_en ? `FPME_PULSES_RC : `FPME_PULSES_EXT;
    assign byte_evt = r.tg_s2 ^ r.tg_s3;
    assign ram_we   = (r.state == FPME_ST_COMM) && byte_evt && (r.rx_cnt < `FPME_RX_FULL);

    always_comb begin
        n            = r;
        n.pin_s1     = i_reset_pin_n;
        n.pin_s2     = r.pin_s1;
        n.g_s1       = lnk_gray;
        n.g_s2       = r.g_s1;
        n.tg_s1      = lnk_tog;
        n.tg_s2      = r.tg_s1;
        n.tg_s3      = r.tg_s2;
        n.cpu_start  = 1'b0;
        n.ram_rdata  = ram[i_ram_addr];
        n.grant      = 1'b0;
        n.deny       = 1'b0;
        n.erase_mask = 3'h0;
        n.ser_oe_n   = ~i_app_ser_clk_drive;
        n.ser_pu     = ~i_app_ser_clk_drive;
        case (r.state)
            FPME_ST_RUN: begin
                if (!r.pin_s2) begin
                    // snapshot so only pulses during this reset count
                    n.base  = fpme_gray2bin(r.g_s2);
                    n.state = FPME_ST_ENTRY;
                end
            end
            FPME_ST_ENTRY: begin
                n.ser_oe_n = 1'b1;
                n.ser_pu   = 1'b1;
                if (r.pin_s2) begin
                    n.cpu_start = 1'b1;
                    n.rx_cnt    = 8'h00;
                    if (pulses == need) begin
                        n.state   = FPME_ST_COMM;
                        n.vec_sys = 1'b1;
                        if (!i_opt_bytes_en) begin
                            n.clk_src = FPME_CLK_EXT_INPUT;
                        end else if (i_opt_main_rc_sel) begin
                            n.clk_src = FPME_CLK_MAIN_RC;
                        end else begin
                            n.clk_src = FPME_CLK_WAKEUP_RC;
                        end
                    end else begin
                        n.state   = FPME_ST_RUN;
                        n.vec_sys = 1'b0;
                        n.clk_src = FPME_CLK_APP;
                    end
                end
            end
            FPME_ST_COMM: begin
                // the tool owns reset; a new low restarts entry
                if (!r.pin_s2) begin
                    n.base  = fpme_gray2bin(r.g_s2);
                    n.state = FPME_ST_ENTRY;
                end else if (ram_we) begin
                    n.rx_cnt = r.rx_cnt + 8'h01;
                end
            end
            default: begin
                n.state = FPME_ST_RUN;
            end
        endcase
        if (i_flash_req.valid) begin
            if (flash_ok(r.state, i_iap_active, i_flash_req)) begin
                n.grant = 1'b1;
                if (i_flash_req.op == FPME_OP_ERASE) begin
                    // one-hot so neighbouring sectors stay untouched
                    case (i_flash_req.sector)
                        FPME_SEC0: n.erase_mask = `FPME_ERASE_SEC0;
                        FPME_SEC1: n.erase_mask = `FPME_ERASE_SEC1;
                        FPME_OPT:  n.erase_mask = `FPME_ERASE_OPT;
                        default:   n.erase_mask = 3'h0;
                    endcase
                end
            end else begin
                n.deny = 1'b1;
            end
        end
    end

    always_ff @(posedge i_core_clk) begin
        if (i_reset) begin
            r            <= '0;
            r.state      <= FPME_ST_RUN;
            r.pin_s1     <= 1'b1;
            r.pin_s2     <= 1'b1;
            r.clk_src    <= FPME_CLK_APP;
            r.ser_oe_n   <= `FPME_RST_SER_OE_N;
            r.ser_pu     <= `FPME_RST_SER_PU;
        end else begin
            r <= n;
        end
    end

    // byte is stable here: the next one needs eight more serial edges
    always_ff @(posedge i_core_clk) begin
        if (ram_we) begin
            ram[r.rx_cnt[`FPME_RAM_AW-1:0]] <= lnk_byte;
        end
    end

    // comm is the only state with bit 1 set, so no decode after the flop
    assign o_in_circuit_comm = r.state[1];
    assign o_vec_sys         = r.vec_sys;
    assign o_cpu_start       = r.cpu_start;
    assign o_clk_src         = r.clk_src;
    assign o_rx_cnt          = r.rx_cnt;
    assign o_ram_rdata       = r.ram_rdata;
    assign o_flash_grant     = r.grant;
    assign o_flash_deny      = r.deny;
    assign o_erase_mask      = r.erase_mask;
    assign o_ser_clk_oe_n    = r.ser_oe_n;
    assign o_ser_clk_pu      = r.ser_pu;

endmodule : fpme_entry

// file: src/fpme_cfg.svh
/*
 * Constants for the flash program mode entry block: entry pulse counts,
 * row and RAM sizes, field widths and reset values.
 * Assumes it is included by bare name from design and checker files.
 */
`ifndef FPME_CFG_SVH
`define FPME_CFG_SVH

`define FPME_CNT_W          6
`define FPME_PULSES_EXT     6'h23
`define FPME_PULSES_RC      6'h26
`define FPME_ROW_MAX        6'h20
`define FPME_RAM_DEPTH      128
`define FPME_RAM_AW         7
`define FPME_RX_FULL        8'h80
`define FPME_ERASE_SEC0     3'h1
`define FPME_ERASE_SEC1     3'h2
`define FPME_ERASE_OPT      3'h4
`define FPME_RST_SER_OE_N   1'h1
`define FPME_RST_SER_PU     1'h1

`endif

// file: src/fpme_pkg.sv
/*
 * Types of the flash program mode entry block: states, clock sources,
 * flash request layout and the registered state of both clock domains.
 * Assumes fpme_cfg.svh defines the widths used here.
 */
`include "fpme_cfg.svh"

package fpme_pkg;

    typedef enum logic [1:0] {
        FPME_ST_RUN   = 2'b00,
        FPME_ST_ENTRY = 2'b01,
        FPME_ST_COMM  = 2'b10
    } fpme_state_t;

    typedef enum logic [1:0] {
        FPME_CLK_APP        = 2'b00,
        FPME_CLK_EXT_INPUT  = 2'b01,
        FPME_CLK_MAIN_RC    = 2'b10,
        FPME_CLK_WAKEUP_RC  = 2'b11
    } fpme_clk_src_t;

    typedef enum logic [1:0] {
        FPME_SEC0 = 2'b00,
        FPME_SEC1 = 2'b01,
        FPME_OPT  = 2'b10
    } fpme_sector_t;

    typedef enum logic [1:0] {
        FPME_OP_BYTE  = 2'b00,
        FPME_OP_ROW   = 2'b01,
        FPME_OP_ERASE = 2'b10
    } fpme_op_t;

    typedef struct packed {
        logic                       valid;
        fpme_sector_t               sector;
        fpme_op_t                   op;
        logic [`FPME_CNT_W-1:0]     len;
    } fpme_flash_req_t;

    typedef struct packed {
        logic                       rst_s1;
        logic                       rst_s2;
        logic                       pin_s1;
        logic                       pin_s2;
        logic [`FPME_CNT_W-1:0]     cnt;
        logic [`FPME_CNT_W-1:0]     gray;
        logic [7:0]                 shift;
        logic [2:0]                 bits;
        logic [7:0]                 rx_byte;
        logic                       tog;
    } fpme_link_t;

    typedef struct packed {
        fpme_state_t                state;
        logic                       pin_s1;
        logic                       pin_s2;
        logic [`FPME_CNT_W-1:0]     g_s1;
        logic [`FPME_CNT_W-1:0]     g_s2;
        logic [`FPME_CNT_W-1:0]     base;
        logic                       tg_s1;
        logic                       tg_s2;
        logic                       tg_s3;
        logic [7:0]                 rx_cnt;
        logic [7:0]                 ram_rdata;
        fpme_clk_src_t              clk_src;
        logic                       vec_sys;
        logic                       cpu_start;
        logic                       grant;
        logic                       deny;
        logic [2:0]                 erase_mask;
        logic                       ser_oe_n;
        logic                       ser_pu;
    } fpme_core_t;

    function automatic logic [`FPME_CNT_W-1:0] fpme_gray2bin(
        input logic [`FPME_CNT_W-1:0] g);
        logic [`FPME_CNT_W-1:0] b;
        b[`FPME_CNT_W-1] = g[`FPME_CNT_W-1];
        for (int k = `FPME_CNT_W - 2; k >= 0; k--) begin
            b[k] = b[k+1] ^ g[k];
        end
        return b;
    endfunction : fpme_gray2bin

    function automatic logic [`FPME_CNT_W-1:0] fpme_bin2gray(
        input logic [`FPME_CNT_W-1:0] b);
        return b ^ (b >> 1);
    endfunction : fpme_bin2gray

endpackage : fpme_pkg

// file: src/fpme_link.sv
/*
 * Link side of the entry block, clocked by the tool's serial clock.
 * Counts serial clock pulses into a gray counter and shifts in bytes
 * from the serial data pin, msb first, handing each byte over by toggle.
 * Assumes the serial data pin changes away from the rising serial edge.
 */
`timescale 1ns/10ps
`include "fpme_cfg.svh"

module fpme_link
    import fpme_pkg::*;
(
    input  wire logic                   i_link_clk,
    input  wire logic                   i_reset,
    input  wire logic                   i_reset_pin_n,
    input  wire logic                   i_ser_data,
    output logic [`FPME_CNT_W-1:0]      o_gray,
    output logic [7:0]                  o_byte,
    output logic                        o_byte_tog
);

    fpme_link_t r;
    fpme_link_t n;

    ////////////////////////////////////////////////////////////////////////
    always_comb begin
        n        = r;
        n.rst_s1 = i_reset;
        n.rst_s2 = r.rst_s1;
        n.pin_s1 = i_reset_pin_n;
        n.pin_s2 = r.pin_s1;
        if (r.rst_s2) begin
            n.cnt     = '0;
            n.gray    = '0;
            n.bits    = 3'h0;
            n.shift   = 8'h00;
            n.rx_byte = 8'h00;
            n.tog     = 1'b0;
        end else begin
            // every edge counts; the core side takes the difference
            n.cnt   = r.cnt + 1'b1;
            n.gray  = fpme_bin2gray(n.cnt);
            n.shift = {r.shift[6:0], i_ser_data};
            if (!r.pin_s2) begin
                // pin sync lags two edges of a stopped clock, and
                // those two edges already carry the first two bits
                n.bits = 3'h2;
            end else begin
                n.bits = r.bits + 3'h1;
                if (r.bits == 3'h7) begin
                    n.rx_byte = {r.shift[6:0], i_ser_data};
                    n.tog     = ~r.tog;
                end
            end
        end
    end

    always_ff @(posedge i_link_clk) begin
        r <= n;
    end

    assign o_gray     = r.gray;
    assign o_byte     = r.rx_byte;
    assign o_byte_tog = r.tog;

endmodule : fpme_link

// file: tb/fpme_entry_asserts.sv
/*
 * Port checks for fpme_entry: flash request answers by mode, entry results.
 * Assumes fpme_pkg and fpme_cfg.svh compile first; bound below.
 */
`timescale 1ns/10ps
`include "fpme_cfg.svh"

module fpme_entry_asserts
    import fpme_pkg::*;
(
    input wire logic            i_core_clk,
    input wire logic            i_reset,
    input wire logic            i_reset_pin_n,
    input wire logic            i_opt_bytes_en,
    input wire logic            i_opt_main_rc_sel,
    input wire logic            i_iap_active,
    input wire fpme_flash_req_t i_flash_req,
    input wire logic            o_in_circuit_comm,
    input wire logic            o_vec_sys,
    input wire logic            o_cpu_start,
    input wire fpme_clk_src_t   o_clk_src,
    input wire logic            o_flash_grant,
    input wire logic            o_flash_deny,
    input wire logic [2:0]      o_erase_mask,
    input wire logic            o_ser_clk_oe_n,
    input wire logic            o_ser_clk_pu
);
    default clocking cb @(posedge i_core_clk); endclocking
    default disable iff (i_reset);

    ////////////////////////////////////////////////////////////////
    sequence s_req;
        i_flash_req.valid;
    endsequence
    sequence s_iap_req;
        s_req ##0 (!o_in_circuit_comm && i_iap_active);
    endsequence
    sequence s_entry_done;
        o_cpu_start && o_vec_sys;
    endsequence

    chk_answer_once: assert property (s_req |=> o_flash_grant != o_flash_deny)
        else $error("request not answered once");
    chk_quiet_idle: assert property (!i_flash_req.valid |=> !o_flash_grant && !o_flash_deny)
        else $error("answer without request");
    chk_row_limit: assert property (s_req ##0 (i_flash_req.op == FPME_OP_ROW &&
        (i_flash_req.len == 6'h00 || i_flash_req.len > 6'h20)) |=> o_flash_deny)
        else $error("bad row length granted");
    chk_tool_erase: assert property (s_req ##0 (o_in_circuit_comm &&
        i_flash_req.op == FPME_OP_ERASE && i_flash_req.sector != 2'h3) |=> o_flash_grant
        && o_erase_mask == (3'h1 << $past(i_flash_req.sector))) else $error("tool erase");
    chk_iap_sec1: assert property (s_iap_req ##0 (i_flash_req.sector == FPME_SEC1 &&
        i_flash_req.op == FPME_OP_ERASE) |=> o_flash_grant && o_erase_mask == 3'h2)
        else $error("sector 1 erase refused");
    chk_iap_sec0: assert property (s_iap_req ##0 (i_flash_req.sector == FPME_SEC0)
        |=> o_flash_deny && o_erase_mask == 3'h0) else $error("sector 0 not protected");
    chk_reset_pin_mode: assert property ($fell(i_reset) |-> o_ser_clk_oe_n && o_ser_clk_pu)
        else $error("serial clock pin not input with pull-up");
    chk_start_release: assert property (o_cpu_start |-> $past(i_reset_pin_n, 2)
        ##1 !o_cpu_start) else $error("start while reset pin low");
    chk_comm_vector: assert property (o_in_circuit_comm |-> o_vec_sys &&
        o_clk_src != FPME_CLK_APP) else $error("comm mode without system vector");
    chk_ext_clock: assert property (s_entry_done ##0 !i_opt_bytes_en |->
        o_clk_src == FPME_CLK_EXT_INPUT) else $error("short entry not on external clock");
    chk_rc_clock: assert property (s_entry_done ##0 i_opt_bytes_en |-> o_clk_src ==
        (i_opt_main_rc_sel ? FPME_CLK_MAIN_RC : FPME_CLK_WAKEUP_RC)) else $error("rc pick");
endmodule : fpme_entry_asserts

bind fpme_entry fpme_entry_asserts fpme_entry_asserts_inst (
    .i_core_clk(i_core_clk), .i_reset(i_reset), .i_reset_pin_n(i_reset_pin_n),
    .i_opt_bytes_en(i_opt_bytes_en), .i_opt_main_rc_sel(i_opt_main_rc_sel),
    .i_iap_active(i_iap_active), .i_flash_req(i_flash_req),
    .o_in_circuit_comm(o_in_circuit_comm), .o_vec_sys(o_vec_sys),
    .o_cpu_start(o_cpu_start), .o_clk_src(o_clk_src), .o_flash_grant(o_flash_grant),
    .o_flash_deny(o_flash_deny), .o_erase_mask(o_erase_mask),
    .o_ser_clk_oe_n(o_ser_clk_oe_n), .o_ser_clk_pu(o_ser_clk_pu));

// file: tb/fpme_tool.sv
/*
 * Programming tool model: owns the reset pin, clocks only inside frames.
 * Assumes the bench calls enter before sending driver bytes.
 */
`timescale 1ns/10ps

module fpme_tool (
    output logic o_reset_pin_n,
    output logic o_serial_clock,
    output logic o_serial_data
);
    initial begin
        o_reset_pin_n  = 1'b1;
        o_serial_clock = 1'b1;
        o_serial_data  = 1'b0;
    end

    // data moves on the falling edge, well clear of the sampling edge
    task automatic pulse(input logic d);
        o_serial_clock = 1'b0;
        o_serial_data  = d;
        #6;
        o_serial_clock = 1'b1;
        #6;
    endtask : pulse

    // long holds either side so the core sync sees the whole count
    task automatic enter(input int n);
        o_reset_pin_n = 1'b0;
        #100;
        for (int k = 0; k < n; k++) pulse(k[0]);
        #100;
        o_reset_pin_n = 1'b1;
        o_serial_data = ~o_serial_data;
    endtask : enter

    task automatic send_byte(input logic [7:0] b, input int gap);
        for (int k = 7; k >= 0; k--) begin
            pulse(b[k]);
            #(gap);
        end
        o_serial_data = ~o_serial_data;
    endtask : send_byte
endmodule : fpme_tool

// file: tb/fpme_entry_bench.sv
/*
 * Self-checking bench for fpme_entry with the tool model on its pins.
 * Assumes the checker binds itself from its own file.
 */
`timescale 1ns/10ps

module fpme_entry_bench
    import fpme_pkg::*;
;
    logic            core_clk, reset, opt_en, rc_sel, in_application_programming, app_drive;
    logic            comm, vec_sys, cpu_start, grant, deny, oe_n, pu;
    logic            pin_n, ser_clk, ser_data;
    logic [6:0]      ram_addr;
    logic [7:0]      rx_cnt, ram_rdata;
    logic [2:0]      erase_mask;
    fpme_clk_src_t   clk_src;
    fpme_flash_req_t flash_req;
    int              bad_count, n_compared;

    always #10 core_clk = ~core_clk;

    fpme_tool fpme_tool_inst (.o_reset_pin_n(pin_n), .o_serial_clock(ser_clk),
        .o_serial_data(ser_data));
    fpme_entry fpme_entry_inst (.i_core_clk(core_clk), .i_reset(reset),
        .i_prog_serial_clock(ser_clk), .i_prog_serial_data(ser_data), .i_reset_pin_n(pin_n),
        .i_opt_bytes_en(opt_en), .i_opt_main_rc_sel(rc_sel), .i_iap_active(in_application_programming),
        .i_app_ser_clk_drive(app_drive), .i_flash_req(flash_req), .i_ram_addr(ram_addr),
        .o_in_circuit_comm(comm), .o_vec_sys(vec_sys), .o_cpu_start(cpu_start),
        .o_clk_src(clk_src), .o_rx_cnt(rx_cnt), .o_ram_rdata(ram_rdata),
        .o_flash_grant(grant), .o_flash_deny(deny), .o_erase_mask(erase_mask),
        .o_ser_clk_oe_n(oe_n), .o_ser_clk_pu(pu));

    ////////////////////////////////////////////////////////////////
    task automatic compare(input logic [7:0] got, input logic [7:0] exp);
        n_compared++;
        if (got !== exp) begin
            bad_count++;
            $display("ERROR at %0t: got %0h expected %0h", $time, got, exp);
        end
    endtask : compare

    task automatic complete_run();
        if (bad_count == 0 && n_compared > 0) $display("SIMULATION PASSED");
        else $display("SIMULATION FAILED");
        $finish;
    endtask : complete_run

    // the application keeps asking for an output throughout
    task automatic t_reset_pins();
        @(negedge core_clk);
        compare(oe_n, 1'b0);
        reset = 1'b1;
        @(negedge core_clk);
        compare(oe_n, 1'b1);
        compare(pu, 1'b1);
        repeat (2) @(negedge core_clk);
        reset = 1'b0;
    endtask : t_reset_pins

    task automatic t_entry(input int n, input logic opt, input logic rc, input logic ok,
                           input fpme_clk_src_t src);
        int k;
        @(negedge core_clk);
        opt_en = opt;
        rc_sel = rc;
        fork
            fpme_tool_inst.enter(n);
            begin
                #200;
                compare(oe_n, 1'b1);
                compare(pu, 1'b1);
            end
        join
        for (k = 0; k < 12 && cpu_start !== 1'b1; k++) @(negedge core_clk);
        compare(cpu_start, 1'b1);
        compare(vec_sys, ok);
        compare(comm, ok);
        compare(clk_src, src);
    endtask : t_entry

    // middle byte sent slowly, the others back to back
    task automatic t_bytes();
        logic [7:0] exp [3] = '{8'hA5, 8'h3C, 8'h81};
        #100;
        for (int k = 0; k < 3; k++) fpme_tool_inst.send_byte(exp[k], (k == 1) ? 30 : 0);
        repeat (6) @(negedge core_clk);
        compare(rx_cnt, 8'h03);
        for (int k = 0; k < 3; k++) begin
            ram_addr = k[6:0];
            @(negedge core_clk);
            compare(ram_rdata, exp[k]);
        end
    endtask : t_bytes

    task automatic t_req(input fpme_sector_t s, input fpme_op_t op, input logic [5:0] len,
                         input logic ok, input logic [2:0] mask);
        @(negedge core_clk);
        flash_req = '{1'b1, s, op, len};
        @(negedge core_clk);
        flash_req.valid = 1'b0;
        compare(grant, ok);
        compare(deny, !ok);
        compare(erase_mask, mask);
    endtask : t_req

    initial begin
        #100000;
        bad_count++;
        complete_run();
    end

    initial begin
        core_clk = 1'b0;
        reset = 1'b1;
        opt_en = 1'b0;
        rc_sel = 1'b0;
        in_application_programming = 1'b0;
        app_drive = 1'b1;
        ram_addr = 7'h00;
        flash_req = '0;
        fork
            repeat (3) @(negedge core_clk);
            repeat (6) fpme_tool_inst.pulse(1'b1);
        join
        @(negedge core_clk);
        reset = 1'b0;
        repeat (4) fpme_tool_inst.pulse(1'b1);
        t_reset_pins();
        t_entry(35, 1'b0, 1'b0, 1'b1, FPME_CLK_EXT_INPUT);
        t_bytes();
        t_req(FPME_SEC0, FPME_OP_ERASE, 6'h00, 1'b1, 3'h1);
        t_req(FPME_SEC1, FPME_OP_ERASE, 6'h00, 1'b1, 3'h2);
        t_req(FPME_OPT, FPME_OP_ERASE, 6'h00, 1'b1, 3'h4);
        t_req(FPME_SEC0, FPME_OP_ROW, 6'h20, 1'b1, 3'h0);
        t_req(FPME_SEC1, FPME_OP_ROW, 6'h21, 1'b0, 3'h0);
        t_req(FPME_OPT, FPME_OP_ROW, 6'h00, 1'b0, 3'h0);
        t_req(FPME_SEC1, FPME_OP_BYTE, 6'h00, 1'b1, 3'h0);
        t_entry(38, 1'b1, 1'b1, 1'b1, FPME_CLK_MAIN_RC);
        t_entry(38, 1'b1, 1'b0, 1'b1, FPME_CLK_WAKEUP_RC);
        t_entry(35, 1'b1, 1'b0, 1'b0, FPME_CLK_APP);
        t_entry(36, 1'b0, 1'b0, 1'b0, FPME_CLK_APP);
        in_application_programming = 1'b1;
        t_req(FPME_SEC1, FPME_OP_ERASE, 6'h00, 1'b1, 3'h2);
        t_req(FPME_SEC1, FPME_OP_ROW, 6'h20, 1'b1, 3'h0);
        t_req(FPME_SEC0, FPME_OP_ERASE, 6'h00, 1'b0, 3'h0);
        t_req(FPME_SEC0, FPME_OP_BYTE, 6'h00, 1'b0, 3'h0);
        in_application_programming = 1'b0;
        t_req(FPME_SEC1, FPME_OP_BYTE, 6'h00, 1'b0, 3'h0);
        complete_run();
    end
endmodule : fpme_entry_bench
